// ---- verilog/otp_space_pkg.sv ----
// Package: one-time-programmable space layout, register types and timing constants
// Behaviour
// - Separate 1024-byte one-time-programmable space
// - 32 regions of 32 aligned bytes each
// - Bytes 000-00F factory random, host cannot program
// - Lock bytes: programmed lock bit refuses region forever
// - Locks at 010-013, bit zero means locked
// - Reserved bytes 014-01F programmable, unreliable later
// - Delivery state FF except random value
// - Regions 1 to 31 open to user programming
// - Freeze bit config_reg_one[0] blocks all programming
// - Freeze stays set until reset
// - Registers reached only by dedicated commands
// - Volatile bits return to defaults on reset
// - Non-volatile bits survive all resets
// - Locked-region program sets program error bit
package otp_space_pkg;

    // ********************************************************
    // Space geometry
    // ********************************************************
    localparam int          OTP_BYTES      = 1024;
    localparam int          REGION_BYTES   = 32;
    localparam int          REGION_COUNT   = OTP_BYTES / REGION_BYTES;
    localparam int          ADDR_W         = 10;
    localparam int          REGION_W       = 5;
    localparam logic [9:0]  RANDOM_LAST    = 10'h00F;
    localparam logic [9:0]  LOCK_FIRST     = 10'h010;
    localparam logic [9:0]  LOCK_LAST      = 10'h013;
    localparam logic [9:0]  RSVD_FIRST     = 10'h014;
    localparam logic [9:0]  RSVD_LAST      = 10'h01F;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

    // ********************************************************
    // Register field positions and volatile defaults
    // ********************************************************
    localparam int          CFG_FREEZE_BIT = 0;
    localparam int          STS_BUSY_BIT   = 0;
    localparam int          STS_WEL_BIT    = 1;
    localparam int          STS_PERR_BIT   = 6;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  STS_RESET      = 8'h00;

    // ********************************************************
    // Timing: cell program time and its cycle count
    // ********************************************************
    localparam int          CLK_MHZ        = 250;
    localparam int          PROG_TIME_NS   = 40;
    localparam int          PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

    // ********************************************************
    // Commands and types
    // ********************************************************
    typedef enum logic [2:0]
    {
        CMD_NONE, CMD_READ, CMD_PROGRAM, CMD_WRITE_ENABLE, CMD_WRITE_DISABLE,
        CMD_WRITE_CONFIG, CMD_CLEAR_STATUS
    } otp_cmd_t;

    typedef struct packed
    {
        otp_cmd_t         cmd;
        logic [9:0]       addr;
        logic [7:0]       data;
    } otp_req_t;

    typedef struct packed
    {
        logic [7:0]       readData;
        logic [7:0]       status;
        logic [7:0]       configRegOne;
    } otp_rsp_t;

endpackage : otp_space_pkg

// ---- verilog/otp_cell_array.sv ----
// Module: non-volatile one-time-programmable byte array, bits only ever cleared
`timescale 1ns/1ps
`default_nettype none
module otp_cell_array
    import otp_space_pkg::*;
#(
    parameter int                DEPTH  = OTP_BYTES,
    parameter logic [127:0]      RANDOM = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
)
(
    // Clock
    input  wire logic            clk,
    // Program port
    input  wire logic            progStrobe,
    input  wire logic [9:0]      progAddr,
    input  wire logic [7:0]      progData,
    // Read port
    input  wire logic [9:0]      readAddr,
    output logic      [7:0]      readByte,
    // Lock bytes seen as a whole
    output logic      [31:0]     lockBits
);

    // Cells hold their state across every reset; no reset term on purpose
    logic [7:0]  cells [DEPTH];
    logic [7:0]  next_cell;

    // Initial contents model the factory delivery state
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            cells[i] = (i < 16) ? RANDOM[i*8 +: 8] : ERASED_BYTE;
        end
    end

    // Programming can only pull bits low
    always_comb
    begin
        next_cell = cells[progAddr] & progData;
    end

    always_ff @(posedge clk)
    begin
        if (progStrobe)
        begin
            cells[progAddr] <= next_cell;
        end
        readByte <= cells[readAddr];
    end

    // Lock byte 010 bit 0 is region 0, byte 013 bit 7 is region 31
    assign lockBits = {cells[LOCK_LAST], cells[10'h012], cells[10'h011], cells[LOCK_FIRST]};

endmodule : otp_cell_array
`default_nettype wire

// ---- verilog/otp_region_lock.sv ----
// Module: command-driven one-time-programmable space with region locks and freeze
`timescale 1ns/1ps
`default_nettype none
module otp_region_lock
    import otp_space_pkg::*;
#(
    parameter int                PROG_WAIT = PROG_CYCLES
)
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            reset_n,
    // Decoded command from the serial front end
    input  wire logic            cmdValid,
    input  wire otp_req_t        cmdReq,
    output logic                 cmdReady,
    // Answer
    output logic                 rspValid,
    output otp_rsp_t             rsp
);

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [4:0] regionOf(input logic [9:0] a);
        regionOf = a[9:5];
    endfunction : regionOf

    // ********************************************************
    // State
    // ********************************************************
    typedef enum { IDLE, PROGRAM, READWAIT, READOUT } state_t;

    state_t       state;
    state_t       next_state;
    logic [7:0]   status;
    logic [7:0]   next_status;
    logic [7:0]   configRegOne;
    logic [7:0]   next_configRegOne;
    logic [9:0]   addr;
    logic [9:0]   next_addr;
    logic [7:0]   data;
    logic [7:0]   next_data;
    logic [7:0]   waitCount;
    logic [7:0]   next_waitCount;
    logic         next_rspValid;
    logic [7:0]   readData;
    logic [7:0]   next_readData;
    logic [7:0]   cellByte;
    logic [31:0]  lockBits;
    logic         progStrobe;
    logic         refused;
    logic         busy;

    otp_cell_array u_cells
    (
        .clk        (clk),
        .progStrobe (progStrobe),
        .progAddr   (addr),
        .progData   (data),
        .readAddr   (next_addr),
        .readByte   (cellByte),
        .lockBits   (lockBits)
    );

    // Factory bytes, lock bits and freeze all refuse a program
    always_comb
    begin
        refused = (cmdReq.addr <= RANDOM_LAST)
               || !lockBits[regionOf(cmdReq.addr)]
               || configRegOne[CFG_FREEZE_BIT];
    end

    // Program error keeps the device busy until status is cleared
    assign busy     = status[STS_BUSY_BIT];
    assign cmdReady = (state == IDLE);

    // ********************************************************
    // Command sequencing
    // ********************************************************
    always_comb
    begin
        next_state     = state;
        next_status    = status;
        next_configRegOne = configRegOne;
        next_addr      = addr;
        next_data      = data;
        next_waitCount = waitCount;
        next_rspValid  = 1'b0;
        next_readData  = readData;
        progStrobe     = 1'b0;
        case (state)
            IDLE:
            begin
                if (cmdValid)
                begin
                    // Each register has its own command
                    case (cmdReq.cmd)
                        CMD_READ:
                        begin
                            next_addr  = cmdReq.addr;
                            next_state = READWAIT;
                        end
                        CMD_PROGRAM:
                        begin
                            // Program needs write enable and an idle device
                            if (status[STS_WEL_BIT] && !busy)
                            begin
                                if (refused)
                                begin
                                    next_status[STS_PERR_BIT] = 1'b1;
                                    next_status[STS_BUSY_BIT] = 1'b1;
                                    next_rspValid             = 1'b1;
                                end
                                else
                                begin
                                    // Reserved bytes accepted like user regions
                                    next_addr                 = cmdReq.addr;
                                    next_data                 = cmdReq.data;
                                    next_status[STS_BUSY_BIT] = 1'b1;
                                    next_waitCount            = 8'(PROG_WAIT);
                                    next_state                = PROGRAM;
                                end
                            end
                            else
                            begin
                                next_rspValid = 1'b1;
                            end
                        end
                        CMD_WRITE_ENABLE:
                        begin
                            next_status[STS_WEL_BIT] = !busy;
                            next_rspValid            = 1'b1;
                        end
                        CMD_WRITE_DISABLE:
                        begin
                            next_status[STS_WEL_BIT] = 1'b0;
                            next_rspValid            = 1'b1;
                        end
                        CMD_WRITE_CONFIG:
                        begin
                            if (status[STS_WEL_BIT] && !busy)
                            begin
                                // Freeze is sticky: a write can set but never clear it
                                next_configRegOne = cmdReq.data;
                                next_configRegOne[CFG_FREEZE_BIT] |= configRegOne[CFG_FREEZE_BIT];
                                next_status[STS_WEL_BIT] = 1'b0;
                            end
                            next_rspValid = 1'b1;
                        end
                        CMD_CLEAR_STATUS:
                        begin
                            next_status[STS_PERR_BIT] = 1'b0;
                            next_status[STS_BUSY_BIT] = 1'b0;
                            next_rspValid             = 1'b1;
                        end
                        default:
                        begin
                            next_rspValid = 1'b1;
                        end
                    endcase
                end
            end
            PROGRAM:
            begin
                // Write the cell on the last wait cycle, then release
                if (waitCount <= 8'h01)
                begin
                    progStrobe                = 1'b1;
                    next_status[STS_BUSY_BIT] = 1'b0;
                    next_status[STS_WEL_BIT]  = 1'b0;
                    next_rspValid             = 1'b1;
                    next_state                = IDLE;
                end
                else
                begin
                    next_waitCount = waitCount - 8'h01;
                end
            end
            READWAIT:
            begin
                next_state = READOUT;
            end
            READOUT:
            begin
                next_readData = cellByte;
                next_rspValid = 1'b1;
                next_state    = IDLE;
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
    end

    // Volatile control returns to its defaults on every reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state     <= IDLE;
            status    <= STS_RESET;
            configRegOne <= CFG_RESET;
            addr      <= 10'h000;
            data      <= 8'hFF;
            waitCount <= 8'h00;
            rspValid  <= 1'b0;
            readData  <= 8'h00;
        end
        else
        begin
            state     <= next_state;
            status    <= next_status;
            configRegOne <= next_configRegOne;
            addr      <= next_addr;
            data      <= next_data;
            waitCount <= next_waitCount;
            rspValid  <= next_rspValid;
            readData  <= next_readData;
        end
    end

    // Answer word is built from registers only
    assign rsp = '{readData: readData, status: status, configRegOne: configRegOne};

endmodule : otp_region_lock
`default_nettype wire

// ---- dv/otp_region_lock_asserts.sv ----
// Checker: port-level assertions for the OTP command block
`timescale 1ns/1ps
`default_nettype none
module otp_region_lock_asserts
    import otp_space_pkg::*;
(
    // Clock and reset
    input wire logic     clk,
    input wire logic     reset_n,
    // Command and answer
    input wire logic     cmdValid,
    input wire otp_req_t cmdReq,
    input wire logic     cmdReady,
    input wire logic     rspValid,
    input wire otp_rsp_t rsp
);
    // ****
    // Helpers
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic idle;
    // Busy and enable qualify the program and config-write checks
    assign take = cmdValid && cmdReady;
    assign idle = !rsp.status[STS_BUSY_BIT] && rsp.status[STS_WEL_BIT];

    property p_reset_quiet;
        reset_n && !$past(reset_n) |-> !rspValid && rsp == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("answer not cleared");
    property p_wren;
        take && cmdReq.cmd == CMD_WRITE_ENABLE && !rsp.status[STS_BUSY_BIT]
        |=> rspValid && rsp.status[STS_WEL_BIT];
    endproperty
    a_wren: assert property (p_wren) else $error("enable not set");
    property p_wrdi;
        take && cmdReq.cmd == CMD_WRITE_DISABLE |=> rspValid && !rsp.status[STS_WEL_BIT];
    endproperty
    a_wrdi: assert property (p_wrdi) else $error("enable not cleared");
    property p_read_time;
        take && cmdReq.cmd == CMD_READ |=> !cmdReady [*2] ##1 rspValid;
    endproperty
    a_read_time: assert property (p_read_time) else $error("read answer late");
    property p_low_refused;
        take && cmdReq.cmd == CMD_PROGRAM && idle && cmdReq.addr <= RANDOM_LAST
        |=> rspValid && rsp.status[STS_PERR_BIT];
    endproperty
    a_low_refused: assert property (p_low_refused) else $error("random bytes not kept");
    property p_freeze_refused;
        take && cmdReq.cmd == CMD_PROGRAM && idle && rsp.configRegOne[CFG_FREEZE_BIT]
        |=> rspValid && rsp.status[STS_PERR_BIT];
    endproperty
    a_freeze_refused: assert property (p_freeze_refused) else $error("frozen program");
    property p_freeze_set;
        take && cmdReq.cmd == CMD_WRITE_CONFIG && idle |=> rsp.configRegOne[CFG_FREEZE_BIT]
        == ($past(rsp.configRegOne[CFG_FREEZE_BIT]) | $past(cmdReq.data[CFG_FREEZE_BIT]));
    endproperty
    a_freeze_set: assert property (p_freeze_set) else $error("freeze write wrong");
    property p_freeze_sticky;
        rsp.configRegOne[CFG_FREEZE_BIT] |=> rsp.configRegOne[CFG_FREEZE_BIT];
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze dropped");
    property p_perr_hold;
        rsp.status[STS_PERR_BIT] && !(take && cmdReq.cmd == CMD_CLEAR_STATUS)
        |=> rsp.status[STS_PERR_BIT];
    endproperty
    a_perr_hold: assert property (p_perr_hold) else $error("error bit lost");
endmodule : otp_region_lock_asserts
bind otp_region_lock otp_region_lock_asserts chk_u (.clk(clk), .reset_n(reset_n),
    .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady), .rspValid(rspValid),
    .rsp(rsp));
`default_nettype wire

// ---- dv/otp_host_model.sv ----
// Host model: issues one command at a time, request held until taken or 40 cycles pass
`timescale 1ns/1ps
`default_nettype none
module otp_host_model
    import otp_space_pkg::*;
(
    // Clock
    input wire logic     clk,
    // Command side
    output var logic     cmdValid,
    output var otp_req_t cmdReq,
    input wire logic     cmdReady
);
    initial
    begin
        cmdValid = 1'b0;
        cmdReq   = '0;
    end
    // Released request is scrambled so stale values are never trusted
    task automatic send(input otp_req_t req);
        int i;
        @(posedge clk);
        #1;
        cmdValid = 1'b1;
        cmdReq   = req;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (!cmdReady && i < 40);
        #1;
        cmdValid = 1'b0;
        cmdReq   = otp_req_t'(~req);
    endtask : send
endmodule : otp_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Testbench: random and corner traffic through the OTP command block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import otp_space_pkg::*;
;
    logic       clk;
    logic       reset_n;
    logic       cmdValid;
    otp_req_t   cmdReq;
    logic       cmdReady;
    logic       rspValid;
    otp_rsp_t   rsp;
    otp_rsp_t   r;
    logic [7:0] shadow [OTP_BYTES];
    logic       frozen;
    int         n_errors;
    int         tests_run;
    int         k;
    int         n;

    otp_region_lock #(.PROG_WAIT(3)) dut_u (.clk(clk), .reset_n(reset_n),
        .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdReady(cmdReady),
        .rspValid(rspValid), .rsp(rsp));
    otp_host_model host_u (.clk(clk), .cmdValid(cmdValid), .cmdReq(cmdReq),
        .cmdReady(cmdReady));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****
    // Expectations and checks
    // ****
    function automatic logic allowed(input logic [9:0] a);
        return !frozen && a > RANDOM_LAST && shadow[LOCK_FIRST + 10'(a[9:8])][a[7:5]];
    endfunction : allowed

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One command, answer sampled mid-cycle under a bounded wait
    task automatic op(input otp_cmd_t c, input logic [9:0] a, input logic [7:0] d);
        int i;
        host_u.send('{c, a, d});
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end
        while (!rspValid && i < 40);
        if (rspValid)
            r = rsp;
        else
        begin
            n_errors++;
            test_done();
        end
    endtask : op

    // Random bytes are learned first so only their stability is judged
    task automatic prog(input logic [9:0] a, input logic [7:0] d);
        logic ok;
        ok = allowed(a);
        if (a <= RANDOM_LAST)
        begin
            op(CMD_READ, a, 8'h00);
            shadow[a] = r.readData;
        end
        op(CMD_WRITE_ENABLE, a, d);
        op(CMD_PROGRAM, a, d);
        check("perr", {7'h00, !ok}, {7'h00, r.status[STS_PERR_BIT]});
        check("busy", {7'h00, !ok}, {7'h00, r.status[STS_BUSY_BIT]});
        if (ok)
            shadow[a] = shadow[a] & d;
        else
            op(CMD_CLEAR_STATUS, a, d);
        op(CMD_READ, a, 8'h00);
        check("cell", shadow[a], r.readData);
    endtask : prog

    task automatic pulse_reset();
        @(posedge clk);
        #1 reset_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        frozen = 1'b0;
        @(negedge clk);
        check("status", STS_RESET, rsp.status);
        check("config", CFG_RESET, rsp.configRegOne);
    endtask : pulse_reset

    // ****
    // Main sequence
    // ****
    initial
    begin
        reset_n   = 1'b0;
        frozen    = 1'b0;
        n_errors  = 0;
        tests_run = 0;
        void'($urandom(32'hB98B69A3));
        foreach (shadow[i]) shadow[i] = ERASED_BYTE;
        pulse_reset();
        for (k = 0; k < 8; k++)
        begin
            op(CMD_READ, 10'(16 + $urandom_range(1007)), 8'h00);
            check("blank", ERASED_BYTE, r.readData);
        end
        op(CMD_WRITE_DISABLE, 10'h000, 8'h00);
        check("wel", 8'h00, {7'h00, r.status[STS_WEL_BIT]});
        // Program without write enable is dropped quietly, no error and no change
        op(CMD_PROGRAM, 10'h3E0, 8'h00);
        check("nowel perr", 8'h00, {7'h00, r.status[STS_PERR_BIT]});
        op(CMD_READ, 10'h3E0, 8'h00);
        check("nowel cell", ERASED_BYTE, r.readData);
        // Lock corner regions 1 and 31 and one random region
        for (k = 0; k < 3; k++)
        begin
            n = (k == 0) ? 1 : (k == 1) ? 31 : 2 + $urandom_range(28);
            prog(LOCK_FIRST + 10'(n / 8), ~(8'h01 << (n % 8)));
            prog(10'(n * 32 + $urandom_range(31)), 8'($urandom));
        end
        for (k = 0; k < 40; k++)
        begin
            if ($urandom_range(3) == 0)
                prog(10'($urandom_range(15)), 8'($urandom));
            else
                prog(10'(20 + $urandom_range(1003)), 8'($urandom));
        end
        prog(RSVD_LAST, 8'h5A);
        // Leave write enable set so the reset has a volatile bit to clear
        op(CMD_WRITE_ENABLE, 10'h000, 8'h00);
        pulse_reset();
        for (k = 16; k < 20; k++)
        begin
            op(CMD_READ, 10'(k), 8'h00);
            check("lock", shadow[k], r.readData);
        end
        op(CMD_WRITE_ENABLE, 10'h000, 8'h00);
        op(CMD_WRITE_CONFIG, 10'h000, 8'h01);
        frozen = 1'b1;
        check("freeze", 8'h01, {7'h00, r.configRegOne[CFG_FREEZE_BIT]});
        prog(10'h040 + 10'($urandom_range(31)), 8'h00);
        op(CMD_WRITE_ENABLE, 10'h000, 8'h00);
        op(CMD_WRITE_CONFIG, 10'h000, 8'h00);
        check("freeze", 8'h01, {7'h00, r.configRegOne[CFG_FREEZE_BIT]});
        pulse_reset();
        test_done();
    end
endmodule : testbench
`default_nettype wire
